// ### design/sdi_pkg.sv
package sdi_pkg;

  localparam int NUM_INPUTS = 16;
  localparam int SYNC_STAGES = 2;

  // clock and indicator timing
  localparam longint CLOCK_HZ = 64'h0000_0000_017D_7840;
  localparam longint LED_PHASE_MS = 64'h0000_0000_0000_00C8;
  localparam longint LED_PHASE_CYCLES_L = (LED_PHASE_MS * CLOCK_HZ) / 64'h0000_0000_0000_03E8;
  localparam int LED_PHASE_CYCLES = int'(LED_PHASE_CYCLES_L);
  localparam logic [1:0] SETTLE_CYCLES = 2'h3;

  // byte addresses of the word registers
  localparam logic [4:0] ADDR_CONFIG = 5'h00;
  localparam logic [4:0] ADDR_NET = 5'h04;
  localparam logic [4:0] ADDR_ERR = 5'h08;
  localparam logic [4:0] ADDR_POLARITY = 5'h0C;
  localparam logic [4:0] ADDR_INPUT = 5'h10;
  localparam logic [4:0] ADDR_PAIR = 5'h14;
  localparam logic [4:0] ADDR_BITRATE = 5'h18;

  // field positions
  localparam int CFG_NODE_LSB = 0;
  localparam int CFG_RATE_LSB = 8;
  localparam int CFG_PAIR_BIT = 11;
  localparam int CFG_PARTNER_LSB = 16;
  localparam int CFG_DONE_BIT = 31;
  localparam int NET_CMD_LSB = 0;
  localparam int NET_STATE_LSB = 4;
  localparam int ERR_WARN_BIT = 0;
  localparam int ERR_GUARD_BIT = 1;
  localparam int ERR_BUSOFF_BIT = 2;
  localparam int ERR_TERM_BIT = 8;
  localparam int INPUT_RAW_LSB = 16;

  // network commands written to the net register
  localparam logic [1:0] CMD_START = 2'h1;
  localparam logic [1:0] CMD_STOP = 2'h2;
  localparam logic [1:0] CMD_PREOP = 2'h3;

  // state codes shown in the net register
  localparam logic [1:0] CODE_INIT = 2'h0;
  localparam logic [1:0] CODE_STOPPED = 2'h1;
  localparam logic [1:0] CODE_PREOP = 2'h2;
  localparam logic [1:0] CODE_OPER = 2'h3;

  localparam logic [6:0] NODE_MAX = 7'h63;
  localparam logic [3:0] DIGIT_MAX = 4'h9;
  localparam logic [15:0] POLARITY_RESET = 16'h0000;

  localparam logic [9:0] RATE_KBPS [8] = '{10'h00A, 10'h014, 10'h032, 10'h07D,
                                          10'h0FA, 10'h1F4, 10'h320, 10'h3E8};

  typedef enum logic [2:0] {LED_OFF, LED_SINGLE, LED_DOUBLE, LED_BLINK, LED_ON} sdi_led_mode_t;
  typedef enum logic [1:0] {NET_INIT, NET_STOPPED, NET_PREOP, NET_OPER} sdi_net_state_t;

  typedef struct packed {
    logic [3:0] tens;
    logic [3:0] units;
    logic [3:0] rate;
  } sdi_switch_t;

  typedef struct packed {
    logic pair_mode;
    logic [2:0] rate_code;
    logic [6:0] node_id;
  } sdi_cfg_t;

endpackage

// ### design/sdi_sync.sv
`timescale 1ns/1ps
`default_nettype none
module sdi_sync import sdi_pkg::*; #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  if (WIDTH < 1) begin
    $error("sdi_sync needs a width of at least one");
  end

  // first stage feeds only the second
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule
`default_nettype wire

// ### design/sdi_led_pattern.sv
`timescale 1ns/1ps
`default_nettype none
module sdi_led_pattern import sdi_pkg::*; (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic phase_tick,
  input wire sdi_led_mode_t mode,
  output logic led
);

  // eight phases, six in single flash: flash patterns end in a long dark gap
  logic [2:0] phase;
  logic next_led;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      phase <= 3'h0;
    end else if (phase_tick) begin
      if (mode == LED_SINGLE && phase == 3'h5) begin
        phase <= 3'h0;
      end else begin
        phase <= phase + 3'h1;
      end
    end
  end

  always_comb begin
    case (mode)
      LED_SINGLE: next_led = (phase == 3'h0);
      LED_DOUBLE: next_led = (phase == 3'h0) || (phase == 3'h2);
      LED_BLINK: next_led = phase[0];
      LED_ON: next_led = 1'b1;
      default: next_led = 1'b0;
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      led <= 1'b0;
    end else begin
      led <= next_led;
    end
  end

endmodule
`default_nettype wire

// ### design/sdi_front_end.sv
`timescale 1ns/1ps
`default_nettype none
module sdi_front_end import sdi_pkg::*; #(
  parameter int NUM_IN = NUM_INPUTS,
  parameter int PHASE_CYCLES = LED_PHASE_CYCLES
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire sdi_switch_t switches,
  input wire logic term_switch,
  input wire logic [NUM_IN-1:0] sensed_input,
  input wire logic err_warning_evt,
  input wire logic guard_fail_evt,
  input wire logic bus_off,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output sdi_cfg_t config_out,
  output logic config_valid,
  output logic [6:0] partner_id,
  output logic [9:0] bitrate_kbps,
  output logic [1:0] net_state_code,
  output logic [NUM_IN-1:0] input_state,
  output logic [NUM_IN-1:0] pair_out,
  output logic pair_out_valid,
  output logic run_led,
  output logic err_led,
  output logic term_led,
  output logic [NUM_IN-1:0] input_led
);

  if (NUM_IN != NUM_INPUTS) begin
    $error("register layout serves exactly sixteen inputs");
  end
  if (PHASE_CYCLES < 2) begin
    $error("indicator phase must be at least two cycles");
  end

  localparam int PW = $clog2(PHASE_CYCLES);
  localparam logic [PW-1:0] PHASE_LAST = PW'(PHASE_CYCLES - 1);

  // pin synchronisers
  sdi_switch_t sw_sync;
  logic term_sync;
  logic [NUM_IN-1:0] raw_in;

  sdi_sync #(.WIDTH($bits(sdi_switch_t) + 1)) u_sync_sw (
    .clock(clock),
    .reset_n(reset_n),
    .async_in({switches, term_switch}),
    .sync_out({sw_sync, term_sync})
  );

  sdi_sync #(.WIDTH(NUM_IN)) u_sync_in (
    .clock(clock),
    .reset_n(reset_n),
    .async_in(sensed_input),
    .sync_out(raw_in)
  );

  // switch capture, once per reset
  logic [1:0] settle;
  logic captured;
  logic capture_now;
  logic [3:0] tens_c;
  logic [3:0] units_c;
  logic [6:0] next_node;

  assign capture_now = !captured && (settle == SETTLE_CYCLES);

  // wait until the synchroniser holds post-reset pin levels
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      settle <= 2'h0;
    end else if (settle != SETTLE_CYCLES) begin
      settle <= settle + 2'h1;
    end
  end

  always_comb begin
    tens_c = (sw_sync.tens > DIGIT_MAX) ? DIGIT_MAX : sw_sync.tens;
    units_c = (sw_sync.units > DIGIT_MAX) ? DIGIT_MAX : sw_sync.units;
    next_node = 7'({tens_c, 3'h0}) + 7'({tens_c, 1'b0}) + 7'(units_c);
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      captured <= 1'b0;
      config_out <= '0;
      config_valid <= 1'b0;
      bitrate_kbps <= 10'h000;
      partner_id <= 7'h00;
    end else if (capture_now) begin
      captured <= 1'b1;
      config_valid <= 1'b1;
      config_out.node_id <= next_node;
      config_out.pair_mode <= sw_sync.rate[3];
      config_out.rate_code <= sw_sync.rate[2:0];
      bitrate_kbps <= RATE_KBPS[sw_sync.rate[2:0]];
      if (next_node[0]) begin
        partner_id <= (next_node == NODE_MAX) ? 7'h00 : next_node + 7'h01;
      end else begin
        partner_id <= (next_node == 7'h00) ? 7'h00 : next_node - 7'h01;
      end
    end
  end

  // bus handshake: one wait cycle, then one cycle with waitrequest low
  logic req;
  logic wr_go;
  logic [3:0] wr_cmd_mask;

  assign req = read || write;
  assign wr_go = write && !waitrequest;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= !(req && waitrequest);
    end
  end

  assign wr_cmd_mask = {4{wr_go}} & byteenable;

  // network state machine
  sdi_net_state_t net_state;
  logic [1:0] cmd;

  assign cmd = writedata[NET_CMD_LSB +: 2];

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      net_state <= NET_INIT;
    end else if (capture_now) begin
      if (sw_sync.rate[3]) begin
        net_state <= NET_OPER;
      end else begin
        net_state <= NET_PREOP;
      end
    end else if (captured && address == ADDR_NET && wr_cmd_mask[0]) begin
      case (cmd)
        CMD_START: net_state <= NET_OPER;
        CMD_STOP: net_state <= NET_STOPPED;
        CMD_PREOP: net_state <= NET_PREOP;
        default: net_state <= net_state;
      endcase
    end
  end

  logic [1:0] next_code;

  always_comb begin
    case (net_state)
      NET_STOPPED: next_code = CODE_STOPPED;
      NET_PREOP: next_code = CODE_PREOP;
      NET_OPER: next_code = CODE_OPER;
      default: next_code = CODE_INIT;
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      net_state_code <= CODE_INIT;
    end else begin
      net_state_code <= next_code;
    end
  end

  // sticky error flags, write one to clear; a new event beats the clear
  logic warn_flag;
  logic guard_flag;
  logic err_clr;

  assign err_clr = (address == ADDR_ERR) && wr_cmd_mask[0];

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      warn_flag <= 1'b0;
    end else if (err_warning_evt) begin
      warn_flag <= 1'b1;
    end else if (err_clr && writedata[ERR_WARN_BIT]) begin
      warn_flag <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      guard_flag <= 1'b0;
    end else if (guard_fail_evt) begin
      guard_flag <= 1'b1;
    end else if (err_clr && writedata[ERR_GUARD_BIT]) begin
      guard_flag <= 1'b0;
    end
  end

  // polarity inversion, byte-lane writes
  logic [15:0] polarity;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      polarity <= POLARITY_RESET;
    end else if (address == ADDR_POLARITY) begin
      if (wr_cmd_mask[0]) begin
        polarity[7:0] <= writedata[7:0];
      end
      if (wr_cmd_mask[1]) begin
        polarity[15:8] <= writedata[15:8];
      end
    end
  end

  // input data paths
  logic pair_active;

  assign pair_active = config_out.pair_mode && (net_state == NET_OPER);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      input_state <= '0;
      input_led <= '0;
      term_led <= 1'b0;
      pair_out <= '0;
      pair_out_valid <= 1'b0;
    end else begin
      input_state <= raw_in ^ polarity;
      input_led <= raw_in;
      term_led <= term_sync;
      pair_out_valid <= pair_active;
      if (pair_active) begin
        pair_out <= raw_in ^ polarity;
      end else begin
        pair_out <= '0;
      end
    end
  end

  // indicator phase timer shared by both lights
  logic [PW-1:0] phase_cnt;
  logic phase_tick;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      phase_cnt <= '0;
      phase_tick <= 1'b0;
    end else begin
      phase_tick <= (phase_cnt == PHASE_LAST);
      if (phase_cnt == PHASE_LAST) begin
        phase_cnt <= '0;
      end else begin
        phase_cnt <= phase_cnt + PW'(1);
      end
    end
  end

  sdi_led_mode_t run_mode;
  sdi_led_mode_t err_mode;

  always_comb begin
    case (net_state)
      NET_STOPPED: run_mode = LED_SINGLE;
      NET_PREOP: run_mode = LED_BLINK;
      NET_OPER: run_mode = LED_ON;
      default: run_mode = LED_OFF;
    endcase
  end

  // bus-off outranks guard fail, which outranks a warning
  always_comb begin
    if (bus_off) begin
      err_mode = LED_ON;
    end else if (guard_flag) begin
      err_mode = LED_DOUBLE;
    end else if (warn_flag) begin
      err_mode = LED_SINGLE;
    end else begin
      err_mode = LED_OFF;
    end
  end

  sdi_led_pattern u_run_led (
    .clock(clock),
    .reset_n(reset_n),
    .phase_tick(phase_tick),
    .mode(run_mode),
    .led(run_led)
  );

  sdi_led_pattern u_err_led (
    .clock(clock),
    .reset_n(reset_n),
    .phase_tick(phase_tick),
    .mode(err_mode),
    .led(err_led)
  );

  // read mux, loaded in the wait cycle so it stands at the answer edge
  logic [31:0] next_rd;

  always_comb begin
    next_rd = 32'h0000_0000;
    if (address == ADDR_CONFIG) begin
      next_rd[CFG_NODE_LSB +: 7] = config_out.node_id;
      next_rd[CFG_RATE_LSB +: 3] = config_out.rate_code;
      next_rd[CFG_PAIR_BIT] = config_out.pair_mode;
      next_rd[CFG_PARTNER_LSB +: 7] = partner_id;
      next_rd[CFG_DONE_BIT] = captured;
    end else if (address == ADDR_NET) begin
      next_rd[NET_STATE_LSB +: 2] = next_code;
    end else if (address == ADDR_ERR) begin
      next_rd[ERR_WARN_BIT] = warn_flag;
      next_rd[ERR_GUARD_BIT] = guard_flag;
      next_rd[ERR_BUSOFF_BIT] = bus_off;
      next_rd[ERR_TERM_BIT] = term_sync;
    end else if (address == ADDR_POLARITY) begin
      next_rd[15:0] = polarity;
    end else if (address == ADDR_INPUT) begin
      next_rd[15:0] = raw_in ^ polarity;
      next_rd[INPUT_RAW_LSB +: 16] = raw_in;
    end else if (address == ADDR_PAIR) begin
      next_rd[15:0] = pair_out;
    end else if (address == ADDR_BITRATE) begin
      next_rd[9:0] = bitrate_kbps;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      readdata <= 32'h0000_0000;
    end else if (read && waitrequest) begin
      readdata <= next_rd;
    end
  end

endmodule
`default_nettype wire

// ### bench/sdi_pair_partner.sv
`timescale 1ns/1ps
`default_nettype none
module sdi_pair_partner import sdi_pkg::*; (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [NUM_INPUTS-1:0] pair_out,
  input wire logic pair_out_valid,
  output logic [NUM_INPUTS-1:0] out_drive
);
  // outputs stay off until the pairing link is up, as a real output module would
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      out_drive <= '0;
    end else begin
      out_drive <= pair_out_valid ? pair_out : '0;
    end
  end
endmodule
`default_nettype wire

// ### bench/sdi_front_end_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module sdi_front_end_assertions import sdi_pkg::*; #(
  parameter int NUM_IN = NUM_INPUTS
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic term_switch,
  input wire logic [NUM_IN-1:0] sensed_input,
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  input wire sdi_cfg_t config_out,
  input wire logic config_valid,
  input wire logic [6:0] partner_id,
  input wire logic [9:0] bitrate_kbps,
  input wire logic [1:0] net_state_code,
  input wire logic [NUM_IN-1:0] input_state,
  input wire logic [NUM_IN-1:0] pair_out,
  input wire logic pair_out_valid,
  input wire logic term_led,
  input wire logic [NUM_IN-1:0] input_led
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  sequence s_req;
    (read || write) && waitrequest;
  endsequence
  sequence s_held;
    config_valid ##1 config_valid;
  endsequence
  // pins pass two sync flops and one output flop
  sequence s_pins;
    (config_valid && $stable(sensed_input))[*4];
  endsequence
  sequence s_term;
    (config_valid && $stable(term_switch))[*4];
  endsequence
  property p_ack;
    s_req |=> !waitrequest ##1 waitrequest;
  endproperty
  a_ack: assert property (p_ack) else $error("bus answer late or too long");
  property p_node_max;
    config_valid |-> config_out.node_id <= NODE_MAX;
  endproperty
  a_node_max: assert property (p_node_max) else $error("node id above 99");
  property p_rate;
    s_held |-> bitrate_kbps == RATE_KBPS[config_out.rate_code];
  endproperty
  a_rate: assert property (p_rate) else $error("bit rate does not match code");
  property p_hold;
    s_held |-> $stable(config_out) && $stable(bitrate_kbps);
  endproperty
  a_hold: assert property (p_hold) else $error("configuration moved after capture");
  property p_partner;
    s_held ##0 (config_out.node_id[0] && config_out.node_id != NODE_MAX)
      |-> partner_id == config_out.node_id + 7'h01;
  endproperty
  a_partner: assert property (p_partner) else $error("odd node partner wrong");
  property p_pair_oper;
    $rose(config_valid) && config_out.pair_mode |-> ##[0:2] net_state_code == CODE_OPER;
  endproperty
  a_pair_oper: assert property (p_pair_oper) else $error("pairing did not start");
  property p_pair_off;
    !config_out.pair_mode |-> !pair_out_valid && pair_out == '0;
  endproperty
  a_pair_off: assert property (p_pair_off) else $error("pair output in normal mode");
  property p_pair_data;
    pair_out_valid |-> pair_out == input_state;
  endproperty
  a_pair_data: assert property (p_pair_data) else $error("pair output not inputs");
  property p_led_raw;
    s_pins |-> input_led == sensed_input;
  endproperty
  a_led_raw: assert property (p_led_raw) else $error("input light not raw level");
  property p_term;
    s_term |-> term_led == term_switch;
  endproperty
  a_term: assert property (p_term) else $error("terminator light wrong");
endmodule
bind sdi_front_end sdi_front_end_assertions #(.NUM_IN(NUM_IN)) sdi_front_end_assertions_i (
  .clock, .reset_n, .term_switch, .sensed_input, .read, .write, .waitrequest, .config_out,
  .config_valid, .partner_id, .bitrate_kbps, .net_state_code, .input_state, .pair_out,
  .pair_out_valid, .term_led, .input_led);
`default_nettype wire

// ### bench/tb_sdi_front_end.sv
`timescale 1ns/1ps
`default_nettype none
module tb_sdi_front_end import sdi_pkg::*;;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  sdi_switch_t switches = '0;
  logic term_switch = 1'b0;
  logic err_warning_evt = 1'b0;
  logic guard_fail_evt = 1'b0;
  logic bus_off = 1'b0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [4:0] address = '0;
  logic [31:0] writedata = '0;
  logic [3:0] byteenable = '0;
  logic [15:0] sensed_input = '0;
  logic [31:0] readdata, rq;
  logic waitrequest, config_valid, pair_out_valid, run_led, err_led, term_led;
  sdi_cfg_t config_out;
  logic [6:0] partner_id;
  logic [9:0] bitrate_kbps;
  logic [1:0] net_state_code;
  logic [15:0] input_state, pair_out, input_led, out_drive;
  int mismatches = 0;
  int comparisons = 0;
  int seed = 19057;
  // byte lanes for the next bus call; full word unless a scenario narrows it
  logic [3:0] lanes = 4'hF;
  // short light phases keep the pattern checks brief
  sdi_front_end #(.PHASE_CYCLES(4)) sdi_front_end_i (.clock, .reset_n, .switches,
    .term_switch, .sensed_input, .err_warning_evt, .guard_fail_evt, .bus_off, .address,
    .read, .write, .writedata, .byteenable, .readdata, .waitrequest, .config_out,
    .config_valid, .partner_id, .bitrate_kbps, .net_state_code, .input_state, .pair_out,
    .pair_out_valid, .run_led, .err_led, .term_led, .input_led);
  sdi_pair_partner sdi_pair_partner_i (.clock, .reset_n, .pair_out, .pair_out_valid,
    .out_drive);
  always #20 clock = ~clock;
  function automatic logic [3:0] dig(input logic [3:0] d);
    return (d > 4'h9) ? 4'h9 : d;
  endfunction
  function automatic logic [6:0] node_of(input sdi_switch_t s);
    return 7'(dig(s.tens) * 10 + dig(s.units));
  endfunction
  function automatic logic [9:0] kbps_of(input logic [2:0] r);
    logic [9:0] t [8];
    t = '{10'h00A, 10'h014, 10'h032, 10'h07D, 10'h0FA, 10'h1F4, 10'h320, 10'h3E8};
    return t[r];
  endfunction
  function automatic logic [6:0] mate(input logic [6:0] n);
    if (n == 7'h00 || n == 7'h63) return 7'h00;
    return n[0] ? n + 7'h01 : n - 7'h01;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= d;
    byteenable <= lanes;
    do @(posedge clock); while (waitrequest !== 1'b0);
    rq = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clock);
  endtask
  task automatic boot(input sdi_switch_t s);
    reset_n <= 1'b0;
    switches <= s;
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    repeat (8) @(posedge clock);
    switches <= 12'($random(seed));
    repeat (4) @(posedge clock);
    chk(config_valid, 1);
    chk(config_out, {s.rate[3], s.rate[2:0], node_of(s)});
    chk(bitrate_kbps, kbps_of(s.rate[2:0]));
    chk(partner_id, mate(node_of(s)));
    chk(net_state_code, s.rate[3] ? CODE_OPER : CODE_PREOP);
  endtask
  // counts over a window that holds whole periods of every pattern
  task automatic leds(input int er, input int ee);
    int r, e;
    r = 0;
    e = 0;
    repeat (40) @(posedge clock);
    repeat (96) begin
      @(posedge clock);
      r += int'(run_led);
      e += int'(err_led);
    end
    chk(r, er);
    chk(e, ee);
  endtask
  task automatic inputs(input logic pm);
    logic [15:0] d, p;
    for (int i = 0; i < 6; i++) begin
      p = 16'($random(seed));
      d = (i == 0) ? 16'hFFFF : 16'($random(seed));
      bus(1'b1, ADDR_POLARITY, {16'h0000, p});
      sensed_input <= d;
      term_switch <= d[i];
      repeat (6) @(posedge clock);
      chk(input_led, d);
      chk(input_state, d ^ p);
      chk(term_led, d[i]);
      chk(pair_out_valid, pm);
      chk(pair_out, pm ? d ^ p : 16'h0000);
      chk(out_drive, pm ? d ^ p : 16'h0000);
      bus(1'b0, ADDR_INPUT, 32'h0);
      chk(rq, {d, d ^ p});
      bus(1'b0, ADDR_PAIR, 32'h0);
      chk(rq, pm ? {16'h0000, d ^ p} : 32'h0);
      bus(1'b0, ADDR_ERR, 32'h0);
      chk(rq[8], d[i]);
    end
  endtask
  task automatic wrap_up;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    sdi_switch_t s;
    logic [1:0] cmd [4];
    logic [1:0] code [4];
    int run [4];
    // the last command is the empty one, which must leave the state alone
    cmd = '{CMD_START, CMD_STOP, CMD_PREOP, 2'h0};
    code = '{CODE_OPER, CODE_STOPPED, CODE_PREOP, CODE_PREOP};
    run = '{96, 16, 48, 48};
    for (int i = 0; i < 18; i++) begin
      s = 12'($random(seed));
      if (i < 16) s.rate = 4'(i);
      if (i == 16) s = 12'h008;
      if (i == 17) s = 12'h99D;
      boot(s);
    end
    boot(12'h325);
    leds(48, 0);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, ADDR_NET, 32'(cmd[i]));
      bus(1'b0, ADDR_NET, 32'h0);
      chk(rq[5:4], code[i]);
      leds(run[i], 0);
    end
    for (int i = 0; i < 2; i++) begin
      err_warning_evt <= (i == 0);
      guard_fail_evt <= (i == 1);
      @(posedge clock);
      err_warning_evt <= 1'b0;
      guard_fail_evt <= 1'b0;
      leds(48, i ? 24 : 16);
    end
    bus(1'b0, ADDR_ERR, 32'h0);
    chk(rq[1:0], 2'h3);
    bus_off <= 1'b1;
    leds(48, 96);
    lanes = 4'hE;
    bus(1'b1, ADDR_ERR, 32'h3);
    lanes = 4'hF;
    bus(1'b0, ADDR_ERR, 32'h0);
    chk(rq[2:0], 3'h7);
    bus_off <= 1'b0;
    bus(1'b1, ADDR_ERR, 32'h3);
    leds(48, 0);
    inputs(1'b0);
    boot(12'h01D);
    bus(1'b0, ADDR_POLARITY, 32'h0);
    chk(rq, 32'h0);
    lanes = 4'h1;
    bus(1'b1, ADDR_POLARITY, 32'h0000_FFFF);
    lanes = 4'h2;
    bus(1'b1, ADDR_POLARITY, 32'h0000_1234);
    lanes = 4'hF;
    bus(1'b0, ADDR_POLARITY, 32'h0);
    chk(rq, 32'h0000_12FF);
    bus(1'b1, ADDR_CONFIG, 32'h0);
    bus(1'b0, ADDR_CONFIG, 32'h0);
    chk(rq, 32'h8002_0D01);
    bus(1'b0, ADDR_BITRATE, 32'h0);
    chk(rq, 32'h0000_01F4);
    bus(1'b0, 5'h1C, 32'h0);
    chk(rq, 32'h0);
    inputs(1'b1);
    leds(96, 0);
    wrap_up();
  end
  initial begin
    #(40 * 20000);
    mismatches++;
    wrap_up();
  end
endmodule
`default_nettype wire
